// >>> verilog/hswc_pkg.sv
package hswc_pkg;

    // stop/wake register location in the expanded register file
    localparam logic [3:0] HSWC_BANK_F        = 4'h0_00F;
    localparam logic [3:0] HSWC_CTRL_OFFSET   = 4'h0_00B;
    localparam logic [7:0] HSWC_CTRL_RESET    = 8'h0_020;

    // field positions of stop_wake_control
    localparam int HSWC_FLAG_BIT    = 7;
    localparam int HSWC_LEVEL_BIT   = 6;
    localparam int HSWC_DELAY_BIT   = 5;
    localparam int HSWC_SRC_LSB     = 2;
    localparam int HSWC_FULL_BIT    = 1;
    localparam int HSWC_DIV16_BIT   = 0;

    // opcodes seen by the sequencer
    localparam logic [7:0] HSWC_OP_NOP  = 8'h0_0FF;
    localparam logic [7:0] HSWC_OP_HALT = 8'h0_07F;
    localparam logic [7:0] HSWC_OP_STOP = 8'h0_06F;

    localparam logic [15:0] HSWC_RESTART_ADDR = 16'h000C;

    // wake source codes
    localparam logic [2:0] HSWC_SRC_RESET_ONLY = 3'h0;
    localparam logic [2:0] HSWC_SRC_P6_B3      = 3'h1;
    localparam logic [2:0] HSWC_SRC_P6_B2      = 3'h2;
    localparam logic [2:0] HSWC_SRC_P2_B7      = 3'h5;
    localparam logic [2:0] HSWC_SRC_NOR_LOW4   = 3'h6;
    localparam logic [2:0] HSWC_SRC_NOR_ALL    = 3'h7;

    // timing
    localparam int HSWC_CLK_PERIOD_PS    = 5000;
    localparam int HSWC_POR_DELAY_NS     = 5000;
    localparam int HSWC_POR_DELAY_CYC    =
        (HSWC_POR_DELAY_NS * 1000 + HSWC_CLK_PERIOD_PS - 1) / HSWC_CLK_PERIOD_PS;
    localparam int HSWC_RESET_HOLD_CYC   = 5;
    localparam int HSWC_PRESCALE_DIV     = 16;
    localparam int HSWC_CNT_W            = 12;
    localparam int HSWC_SYNC_W           = 11;

    typedef struct packed {
        logic       stop_flag;
        logic       wake_high;
        logic       delay_en;
        logic [2:0] wake_src;
        logic       crystal_input_full;
        logic       div16;
    } hswc_ctrl_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] bank;
        logic [3:0] addr;
        logic [7:0] wdata;
    } hswc_reg_req_s;

    typedef enum logic [2:0] {
        HSWC_ST_RUN,
        HSWC_ST_HALT,
        HSWC_ST_STOP,
        HSWC_ST_DELAY,
        HSWC_ST_RESET
    } hswc_state_e;

endpackage

// >>> verilog/hswc_clk_scaler.sv
`timescale 1ns/1ps
module hswc_clk_scaler import hswc_pkg::*; (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic nrst,
    // control
    input  wire logic osc_run,
    input  wire logic crystal_input_full,
    input  wire logic div16,
    // scaled tick
    output logic      tick
);

    logic       half_r;
    logic [3:0] pre_r;
    logic       base;

    // base rate is crystal/2 unless bypassed
    assign base = osc_run & (crystal_input_full | half_r);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            half_r <= 1'b0;
        end else begin
            half_r <= osc_run ? ~half_r : 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pre_r <= 4'h0;
        end else if (base) begin
            pre_r <= pre_r + 4'h1;
        end
    end

    // new division takes effect on the next base tick
    assign tick = base & (!div16 || pre_r == 4'(HSWC_PRESCALE_DIV - 1));

endmodule // hswc_clk_scaler

// >>> verilog/hswc_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - halt opcode stops cpu clock, timers keep running
// - any interrupt ends halt, resumes after halt
// - reset or watchdog in halt restarts at 000Ch
// - clock scaling bits writable anytime, immediate
// - stop opcode stops oscillator and system clock
// - stop ends on reset, watchdog, wake source
// - watchdog running in stop resets out of stop
// - bit7 read-only wake flag, cleared by resets
// - bit6 selects wake level, default low
// - bit5 inserts power-on delay after wake
// - bits4:2 select wake source per code
// - bit1 bypasses crystal divide-by-two
// - bit0 adds divide-by-16 prescaler
// - register at bank F 0Bh, mixed access
// - wake or stop watchdog gives warm initialisation
// - warm restart keeps bits 6:0 unchanged; bit7 is set by a wake, cleared by stop watchdog
module hswc_ctrl import hswc_pkg::*; (
    // clock and reset
    input  wire logic           core_clk,
    input  wire logic           nrst,
    // core execution
    input  wire logic           exec_valid,
    input  wire logic [7:0]     exec_opcode,
    input  wire logic           irq_pending,
    // watchdog
    input  wire logic           wdt_timeout,
    input  wire logic           wdt_run_in_halt,
    input  wire logic           wdt_run_in_stop,
    // external pins
    input  wire logic           reset_pin_n,
    input  wire logic [7:0]     port2_in,
    input  wire logic           wake_pin_port6_bit3,
    input  wire logic           wake_pin_port6_bit2,
    // register port
    input  wire hswc_reg_req_s  reg_req,
    output logic [7:0]          reg_rdata,
    // clock control
    output logic                osc_enable,
    output logic                cpu_clk_en,
    output logic                sys_tick,
    output logic                timer_tick,
    // restart control
    output logic                core_reset,
    output logic                warm_init,
    output logic [15:0]         restart_addr,
    output logic                halt_resume,
    // mode status
    output logic                halt_mode,
    output logic                stop_mode
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [HSWC_SYNC_W-1:0] pin_raw;
    logic [HSWC_SYNC_W-1:0] s0_r;
    logic [HSWC_SYNC_W-1:0] s1_r;
    logic [HSWC_SYNC_W-1:0] s2_r;
    logic [HSWC_SYNC_W-1:0] filt_r;

    assign pin_raw = {reset_pin_n, wake_pin_port6_bit2, wake_pin_port6_bit3, port2_in};

    genvar gi;
    generate
        for (gi = 0; gi < HSWC_SYNC_W; gi++) begin : g_sync
            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    s0_r[gi]   <= 1'b1;
                    s1_r[gi]   <= 1'b1;
                    s2_r[gi]   <= 1'b1;
                    filt_r[gi] <= 1'b1;
                end else begin
                    s0_r[gi] <= pin_raw[gi];
                    s1_r[gi] <= s0_r[gi];
                    s2_r[gi] <= s1_r[gi];
                    // only a settled level counts
                    if (s1_r[gi] == s2_r[gi]) begin
                        filt_r[gi] <= s2_r[gi];
                    end
                end
            end
        end
    endgenerate

    logic       pin_rst_n_s;
    logic       p62_s;
    logic       p63_s;
    logic [7:0] p2_s;

    assign pin_rst_n_s = filt_r[10];
    assign p62_s       = filt_r[9];
    assign p63_s       = filt_r[8];
    assign p2_s        = filt_r[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // wake source selection
    function automatic logic wake_raw(input logic [2:0] src,
                                      input logic [7:0] p2,
                                      input logic       p62,
                                      input logic       p63,
                                      input logic       high);
        logic v;
        logic ok;
        v  = 1'b0;
        ok = 1'b1;
        case (src)
            HSWC_SRC_P6_B3:    v = p63;
            HSWC_SRC_P6_B2:    v = p62;
            HSWC_SRC_P2_B7:    v = p2[7];
            HSWC_SRC_NOR_LOW4: v = ~|p2[3:0];
            HSWC_SRC_NOR_ALL:  v = ~|p2;
            // reset-only and the forbidden codes never wake
            default:           ok = 1'b0;
        endcase
        return ok & (high ? v : ~v);
    endfunction

    hswc_ctrl_s ctrl_r;
    logic       wake_hit;

    // level and source from the register
    assign wake_hit = wake_raw(ctrl_r.wake_src, p2_s, p62_s, p63_s, ctrl_r.wake_high);

    ////////////////////////////////////////////////////////////////////////////
    // event decode
    logic reg_hit;
    logic op_halt;
    logic op_stop;
    logic pin_rst;

    assign reg_hit = reg_req.bank == HSWC_BANK_F && reg_req.addr == HSWC_CTRL_OFFSET;
    assign op_halt = exec_valid && exec_opcode == HSWC_OP_HALT;
    assign op_stop = exec_valid && exec_opcode == HSWC_OP_STOP;
    assign pin_rst = !pin_rst_n_s;

    hswc_state_e         state_r;
    hswc_state_e         state_nxt;
    logic [HSWC_CNT_W-1:0] cnt_r;
    logic [HSWC_CNT_W-1:0] cnt_nxt;
    logic                warm_r;
    logic                warm_nxt;
    logic                std_rst;
    logic                stop_wdt;
    logic                woke;

    ////////////////////////////////////////////////////////////////////////////
    // mode sequencer
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        warm_nxt  = warm_r;
        std_rst   = 1'b0;
        stop_wdt  = 1'b0;
        woke      = 1'b0;
        if (cnt_r != '0) begin
            cnt_nxt = cnt_r - HSWC_CNT_W'(1);
        end
        case (state_r)
            HSWC_ST_RUN: begin
                if (pin_rst || wdt_timeout) begin
                    std_rst = 1'b1;
                end else if (op_stop) begin
                    state_nxt = HSWC_ST_STOP;
                end else if (op_halt) begin
                    state_nxt = HSWC_ST_HALT;
                end
            end
            HSWC_ST_HALT: begin
                if (pin_rst || (wdt_timeout && wdt_run_in_halt)) begin
                    std_rst = 1'b1;
                end else if (irq_pending) begin
                    state_nxt = HSWC_ST_RUN;
                end
            end
            HSWC_ST_STOP: begin
                // interrupts are ignored here
                if (pin_rst) begin
                    std_rst = 1'b1;
                end else if (wdt_timeout && wdt_run_in_stop) begin
                    stop_wdt = 1'b1;
                end else if (wake_hit) begin
                    woke = 1'b1;
                end
            end
            HSWC_ST_DELAY: begin
                if (pin_rst) begin
                    std_rst = 1'b1;
                end else if (cnt_r == '0) begin
                    state_nxt = HSWC_ST_RESET;
                    cnt_nxt   = HSWC_CNT_W'(HSWC_RESET_HOLD_CYC - 1);
                end
            end
            HSWC_ST_RESET: begin
                if (pin_rst) begin
                    std_rst = 1'b1;
                end else if (cnt_r == '0) begin
                    state_nxt = HSWC_ST_RUN;
                    warm_nxt  = 1'b0;
                end
            end
            default: begin
                state_nxt = HSWC_ST_RESET;
                cnt_nxt   = HSWC_CNT_W'(HSWC_RESET_HOLD_CYC - 1);
                warm_nxt  = 1'b0;
            end
        endcase
        if (std_rst) begin
            state_nxt = HSWC_ST_RESET;
            cnt_nxt   = HSWC_CNT_W'(HSWC_RESET_HOLD_CYC - 1);
            warm_nxt  = 1'b0;
        end else if (stop_wdt || woke) begin
            warm_nxt = 1'b1;
            // fast wake relies on the source being held long enough
            if (ctrl_r.delay_en) begin
                state_nxt = HSWC_ST_DELAY;
                cnt_nxt   = HSWC_CNT_W'(HSWC_POR_DELAY_CYC - 1);
            end else begin
                state_nxt = HSWC_ST_RESET;
                cnt_nxt   = HSWC_CNT_W'(HSWC_RESET_HOLD_CYC - 1);
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= HSWC_ST_RESET;
            cnt_r   <= HSWC_CNT_W'(HSWC_RESET_HOLD_CYC - 1);
            warm_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            warm_r  <= warm_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // stop_wake_control register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= hswc_ctrl_s'(HSWC_CTRL_RESET);
        end else begin
            // warm restarts leave the write-only fields alone
            if (std_rst) begin
                ctrl_r.wake_high <= HSWC_CTRL_RESET[HSWC_LEVEL_BIT];
                ctrl_r.delay_en  <= HSWC_CTRL_RESET[HSWC_DELAY_BIT];
                ctrl_r.wake_src  <= HSWC_CTRL_RESET[HSWC_SRC_LSB +: 3];
                ctrl_r.crystal_input_full <= HSWC_CTRL_RESET[HSWC_FULL_BIT];
                ctrl_r.div16     <= HSWC_CTRL_RESET[HSWC_DIV16_BIT];
            end else if (reg_req.wr && reg_hit) begin
                // accepted in every mode, including halt
                ctrl_r.wake_high <= reg_req.wdata[HSWC_LEVEL_BIT];
                ctrl_r.delay_en  <= reg_req.wdata[HSWC_DELAY_BIT];
                ctrl_r.wake_src  <= reg_req.wdata[HSWC_SRC_LSB +: 3];
                ctrl_r.crystal_input_full <= reg_req.wdata[HSWC_FULL_BIT];
                ctrl_r.div16     <= reg_req.wdata[HSWC_DIV16_BIT];
            end
            // flag is hardware owned; a wake beats any clear
            if (woke) begin
                ctrl_r.stop_flag <= 1'b1;
            end else if (std_rst || stop_wdt) begin
                ctrl_r.stop_flag <= 1'b0;
            end
        end
    end

    // only bit 7 is readable; write-only bits read zero
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.rd) begin
            reg_rdata <= reg_hit ? {ctrl_r.stop_flag, 7'h00} : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered mode outputs
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            osc_enable <= 1'b1;
            cpu_clk_en <= 1'b0;
            core_reset <= 1'b1;
            warm_init  <= 1'b0;
            halt_mode  <= 1'b0;
            stop_mode  <= 1'b0;
        end else begin
            osc_enable <= state_nxt != HSWC_ST_STOP;
            cpu_clk_en <= state_nxt == HSWC_ST_RUN;
            core_reset <= state_nxt == HSWC_ST_DELAY ||
                          state_nxt == HSWC_ST_RESET;
            warm_init  <= warm_nxt;
            halt_mode  <= state_nxt == HSWC_ST_HALT;
            stop_mode  <= state_nxt == HSWC_ST_STOP;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            halt_resume <= 1'b0;
        end else begin
            halt_resume <= state_r == HSWC_ST_HALT && state_nxt == HSWC_ST_RUN;
        end
    end

    assign restart_addr = HSWC_RESTART_ADDR;

    ////////////////////////////////////////////////////////////////////////////
    // clock scaling
    logic scaled_tick;

    hswc_clk_scaler u_scaler (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .osc_run   (osc_enable),
        .crystal_input_full (ctrl_r.crystal_input_full),
        .div16     (ctrl_r.div16),
        .tick      (scaled_tick)
    );

    // timers keep ticking in halt, not in stop
    assign timer_tick = scaled_tick;
    assign sys_tick   = scaled_tick & cpu_clk_en;

endmodule // hswc_ctrl

// >>> tb/hswc_ctrl_checker.sv
`timescale 1ns/1ps
module hswc_ctrl_checker import hswc_pkg::*; (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        nrst,
    // core and watchdog
    input wire logic        exec_valid,
    input wire logic [7:0]  exec_opcode,
    input wire logic        irq_pending,
    input wire logic        wdt_timeout,
    input wire logic        wdt_run_in_halt,
    input wire logic        wdt_run_in_stop,
    // outputs
    input wire logic [7:0]  reg_rdata,
    input wire logic        osc_enable,
    input wire logic        cpu_clk_en,
    input wire logic        sys_tick,
    input wire logic        timer_tick,
    input wire logic        core_reset,
    input wire logic        warm_init,
    input wire logic [15:0] restart_addr,
    input wire logic        halt_resume,
    input wire logic        halt_mode,
    input wire logic        stop_mode
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence halt_req_s;
        cpu_clk_en && exec_valid && exec_opcode == HSWC_OP_HALT && !wdt_timeout;
    endsequence
    sequence stop_req_s;
        cpu_clk_en && exec_valid && exec_opcode == HSWC_OP_STOP && !wdt_timeout;
    endsequence
    sequence warm_start_s;
        core_reset && warm_init && !stop_mode;
    endsequence

    ////////////////////////////////////////
    halt_entry_a: assert property (halt_req_s |=> halt_mode && !cpu_clk_en && osc_enable)
        else $error("halt entry wrong");
    halt_quiet_a: assert property (halt_mode |-> osc_enable && !sys_tick)
        else $error("clock active in halt");
    stop_entry_a: assert property (stop_req_s |=> stop_mode && !osc_enable && !cpu_clk_en)
        else $error("stop entry wrong");
    stop_quiet_a: assert property (stop_mode |-> !timer_tick && !sys_tick)
        else $error("tick in stop");
    halt_exit_a: assert property (halt_mode && irq_pending && !wdt_timeout
        |=> halt_resume && cpu_clk_en && !halt_mode)
        else $error("halt not left on interrupt");
    resume_pulse_a: assert property (halt_resume |=> !halt_resume)
        else $error("resume pulse too long");
    stop_wdt_a: assert property (stop_mode && wdt_timeout && wdt_run_in_stop
        |=> warm_start_s)
        else $error("stop watchdog restart wrong");
    halt_wdt_a: assert property (halt_mode && wdt_timeout && wdt_run_in_halt
        |=> core_reset && !warm_init && !halt_mode)
        else $error("halt watchdog restart wrong");
    restart_vec_a: assert property (core_reset |-> restart_addr == HSWC_RESTART_ADDR)
        else $error("restart address wrong");
    read_mask_a: assert property (reg_rdata[6:0] == 7'h00)
        else $error("write-only bits readable");
    warm_hold_a: assert property ($rose(warm_init) |-> core_reset [*5])
        else $error("warm restart too short");
    run_clock_a: assert property ($rose(cpu_clk_en) |-> !core_reset && !halt_mode && !stop_mode)
        else $error("core clock resumed early");
endmodule // hswc_ctrl_checker

bind hswc_ctrl hswc_ctrl_checker chk_u (.*);

// >>> tb/hswc_wake_model.sv
`timescale 1ns/1ps
module hswc_wake_model import hswc_pkg::*; (
    // clock
    input wire logic       core_clk,
    // wake request
    input wire logic       wake_go,
    input wire logic [2:0] wake_src,
    input wire logic       wake_high,
    // pins
    output logic [7:0]     port2_in,
    output logic           wake_pin_port6_bit3,
    output logic           wake_pin_port6_bit2
);
    logic [3:0] hold_r = 4'h0;
    logic       act;

    // stretch so a short request still meets the fast wake minimum
    always @(posedge core_clk) begin
        if (wake_go) begin
            hold_r <= 4'h8;
        end else if (hold_r != 4'h0) begin
            hold_r <= hold_r - 4'h1;
        end
    end

    ////////////////////////////////////////
    assign act = (wake_go || hold_r != 4'h0) ? wake_high : !wake_high;
    // unselected pins sit at the non-waking level
    assign wake_pin_port6_bit3 = (wake_src == HSWC_SRC_P6_B3) ? act : !wake_high;
    assign wake_pin_port6_bit2 = (wake_src == HSWC_SRC_P6_B2) ? act : !wake_high;
    always_comb begin
        case (wake_src)
            HSWC_SRC_P2_B7:    port2_in = {act, {7{!wake_high}}};
            // upper half opposes, so a full-width decode would misfire
            HSWC_SRC_NOR_LOW4: port2_in = {{4{act}}, {4{!act}}};
            HSWC_SRC_NOR_ALL:  port2_in = {8{!act}};
            default:           port2_in = {8{!wake_high}};
        endcase
    end
endmodule // hswc_wake_model

// >>> tb/hswc_ctrl_bench.sv
`timescale 1ns/1ps
module hswc_ctrl_bench import hswc_pkg::*;;
    logic          core_clk = 1'b0;
    logic          nrst = 1'b0;
    logic          reset_pin_n = 1'b1;
    logic          exec_valid = 1'b0;
    logic [7:0]    exec_opcode = HSWC_OP_NOP;
    logic          irq_pending = 1'b0;
    logic          wdt_timeout = 1'b0;
    logic          wdt_run_in_halt = 1'b0;
    logic          wdt_run_in_stop = 1'b0;
    hswc_reg_req_s reg_req = '0;
    logic          wake_go = 1'b0;
    logic          wake_high = 1'b0;
    logic [2:0]    wake_src = 3'h0;
    logic [7:0]    port2_in, reg_rdata;
    logic          wake_pin_port6_bit3, wake_pin_port6_bit2, osc_enable, cpu_clk_en;
    logic          sys_tick, timer_tick, core_reset, warm_init, halt_resume;
    logic          halt_mode, stop_mode;
    logic [15:0]   restart_addr;
    int            err_count = 0;
    int            tests_run = 0;
    int            n0;

    hswc_ctrl dut_u (.*);
    hswc_wake_model wake_u (.*);

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic reg_acc(input logic wr, input logic [3:0] a, input logic [7:0] d);
        reg_req = '{wr, !wr, HSWC_BANK_F, a, d};
        cyc(1);
        reg_req = '0;
        cyc(1);
    endtask

    task automatic run_op(input logic [7:0] op);
        exec_valid = 1'b1;
        exec_opcode = HSWC_OP_NOP;
        cyc(1);
        exec_opcode = op;
        cyc(1);
        exec_valid = 1'b0;
        // let an edge pass so a following call does not re-raise valid in the same step
        cyc(1);
    endtask

    task automatic pulse_wdt;
        wdt_timeout = 1'b1;
        cyc(1);
        wdt_timeout = 1'b0;
        cyc(1);
    endtask

    // counts core reset cycles until the core clock runs again
    task automatic wait_run(output int n);
        int k;
        n = 0;
        for (k = 0; k < 3000 && cpu_clk_en !== 1'b1; k++) begin
            n += (core_reset === 1'b1);
            cyc(1);
        end
    endtask

    task automatic tick_count(input logic [7:0] ctrl, input logic tmr, input int exp);
        int n;
        n = 0;
        reg_acc(1'b1, HSWC_CTRL_OFFSET, ctrl);
        cyc(32);
        repeat (128) begin
            cyc(1);
            n += tmr ? timer_tick : sys_tick;
        end
        chk(n, exp, "tick count");
    endtask

    ////////////////////////////////////////
    task automatic test_regs;
        reg_acc(1'b0, HSWC_CTRL_OFFSET, 8'h00);
        chk(reg_rdata, 8'h00, "cold flag");
        reg_acc(1'b1, HSWC_CTRL_OFFSET, 8'hff);
        reg_acc(1'b0, HSWC_CTRL_OFFSET, 8'h00);
        chk(reg_rdata, 8'h00, "read-only flag");
        reg_acc(1'b0, 4'ha, 8'h00);
        chk(reg_rdata, 8'h00, "unmapped read");
        tick_count(8'h20, 1'b0, 64);
        tick_count(8'h22, 1'b0, 128);
        tick_count(8'h21, 1'b0, 4);
        tick_count(8'h23, 1'b0, 8);
        $display("register test done");
    endtask

    task automatic test_halt;
        int n;
        run_op(HSWC_OP_HALT);
        chk({halt_mode, cpu_clk_en, osc_enable}, 3'b101, "halt entry");
        run_op(HSWC_OP_STOP);
        chk({halt_mode, stop_mode}, 2'b10, "opcode in halt");
        tick_count(8'h22, 1'b1, 128);
        irq_pending = 1'b1;
        cyc(1);
        irq_pending = 1'b0;
        chk({halt_mode, cpu_clk_en, halt_resume}, 3'b011, "halt exit");
        run_op(HSWC_OP_HALT);
        for (int r = 0; r < 2; r++) begin
            wdt_run_in_halt = r[0];
            pulse_wdt();
            chk({halt_mode, core_reset, warm_init}, r ? 3'b010 : 3'b100, "halt wdt");
        end
        wait_run(n);
        wdt_run_in_halt = 1'b0;
        // pin reset passes three synchroniser flops and the filter flop before it acts
        run_op(HSWC_OP_HALT);
        reset_pin_n = 1'b0;
        cyc(6);
        chk({halt_mode, core_reset, warm_init}, 3'b010, "halt pin reset");
        reset_pin_n = 1'b1;
        wait_run(n);
        chk(cpu_clk_en, 1'b1, "run after pin reset");
        $display("halt test done");
    endtask

    task automatic test_wake(input logic [2:0] src, input logic hi, input logic dly);
        int n;
        wake_src = src;
        wake_high = hi;
        cyc(4);
        reg_acc(1'b1, HSWC_CTRL_OFFSET, {1'b0, hi, dly, src, 2'b00});
        run_op(HSWC_OP_STOP);
        chk({stop_mode, osc_enable, timer_tick}, 3'b100, "stop entry");
        cyc(8);
        chk(stop_mode, 1'b1, "idle pins");
        wake_go = 1'b1;
        for (n = 0; n < 20 && core_reset !== 1'b1; n++) cyc(1);
        wake_go = 1'b0;
        chk({stop_mode, warm_init}, 2'b01, "wake restart");
        wait_run(n);
        chk(n, dly ? HSWC_POR_DELAY_CYC + HSWC_RESET_HOLD_CYC : HSWC_RESET_HOLD_CYC,
            "reset span");
        reg_acc(1'b0, HSWC_CTRL_OFFSET, 8'h00);
        chk(reg_rdata, 8'h80, "warm flag");
        $display("wake test done");
    endtask

    task automatic test_stop_wdt;
        int n;
        wake_src = HSWC_SRC_RESET_ONLY;
        reg_acc(1'b1, HSWC_CTRL_OFFSET, 8'h22);
        run_op(HSWC_OP_STOP);
        wake_go = 1'b1;
        irq_pending = 1'b1;
        cyc(12);
        wake_go = 1'b0;
        irq_pending = 1'b0;
        chk(stop_mode, 1'b1, "reset-only source");
        wdt_run_in_stop = 1'b1;
        pulse_wdt();
        chk({stop_mode, core_reset, warm_init}, 3'b011, "stop wdt");
        wait_run(n);
        // full-rate clock survives the warm restart: a tick on two edges in a row
        chk(timer_tick, 1'b1, "kept scaling");
        cyc(1);
        chk(timer_tick, 1'b1, "kept scaling");
        wdt_run_in_stop = 1'b0;
        reg_acc(1'b0, HSWC_CTRL_OFFSET, 8'h00);
        chk(reg_rdata, 8'h00, "flag after wdt");
        $display("stop watchdog test done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    initial begin
        #200_000;
        err_count++;
        $display("wrong value at %0t: run timed out", $time);
        results();
    end

    initial begin
        cyc(4);
        chk({core_reset, cpu_clk_en, halt_mode, stop_mode}, 4'b1000, "in reset");
        nrst = 1'b1;
        wait_run(n0);
        chk(n0, HSWC_RESET_HOLD_CYC, "reset hold");
        chk(restart_addr, HSWC_RESTART_ADDR, "restart address");
        test_regs();
        test_halt();
        // codes 011 and 100 are never written
        test_wake(HSWC_SRC_P6_B3, 1'b0, 1'b0);
        test_wake(HSWC_SRC_P6_B2, 1'b1, 1'b0);
        test_wake(HSWC_SRC_P2_B7, 1'b0, 1'b0);
        test_wake(HSWC_SRC_NOR_LOW4, 1'b1, 1'b0);
        test_wake(HSWC_SRC_NOR_ALL, 1'b0, 1'b0);
        test_wake(HSWC_SRC_P2_B7, 1'b1, 1'b1);
        test_stop_wdt();
        results();
    end
endmodule // hswc_ctrl_bench
